// ---- core/uft_baud.sv ----
// uft_baud: prescaler, divisor and oversampling counter producing
// one-cycle sample and bit enables on the system clock.
// assumes divisor and mode come from registers on the same clock.
`timescale 1ns/100ps
module uft_baud #(
   parameter int DIV_W = 16
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_presc4,
   input  wire logic             i_ovs8,
   input  wire logic [DIV_W-1:0] i_divisor,
   output logic                  o_sample_tick,
   output logic                  o_bit_tick
);
   initial begin
      if (DIV_W < 2) $error("uft_baud: DIV_W must be at least 2");
   end

   logic [1:0]       presc_cnt;
   logic [DIV_W-1:0] div_cnt;
   logic [4:0]       ovs_cnt;
   wire              presc_tick = !i_presc4 || (presc_cnt == uft_pkg::PRESC_DIV4);
   wire              div_zero   = (i_divisor == '0);
   wire              div_wrap   = (div_cnt >= i_divisor - DIV_W'(1));
   wire              div_tick   = presc_tick && !div_zero && div_wrap;
   wire [4:0]        ovs_len    = i_ovs8 ? uft_pkg::OVS_8 : uft_pkg::OVS_16;
   wire              ovs_wrap   = (ovs_cnt >= ovs_len - 5'h01);

   // a zero divisor parks the generator rather than dividing by 2^n
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         presc_cnt     <= 2'h0;
         div_cnt       <= '0;
         ovs_cnt       <= 5'h00;
         o_sample_tick <= 1'b0;
         o_bit_tick    <= 1'b0;
      end else begin
         presc_cnt     <= presc_tick ? 2'h0 : presc_cnt + 2'h1;
         if (presc_tick) begin
            div_cnt    <= div_wrap ? '0 : div_cnt + DIV_W'(1);
         end
         if (div_tick) begin
            ovs_cnt    <= ovs_wrap ? 5'h00 : ovs_cnt + 5'h01;
         end
         o_sample_tick <= div_tick;
         o_bit_tick    <= div_tick && ovs_wrap;
      end
   end
endmodule // uft_baud

// ---- core/uft_flow.sv ----
// uft_flow: fifo trigger-level selection and automatic hardware flow
// control for one uart channel, with its registers on apb.
// assumes rx level and tx idle come from the channel's own fifo and
// shifter on i_clk; modem pins arrive asynchronously.
`timescale 1ns/100ps
module uft_flow #(
   parameter int DIV_W = 16,
   parameter int LVL_W = 7
) (
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [LVL_W-1:0] i_rx_level,
   input  wire logic             i_tx_idle,
   input  wire logic             i_cts_n,
   input  wire logic             i_dsr_n,
   output logic                  o_rts_n,
   output logic                  o_dtr_n,
   output logic                  o_tx_allow,
   output logic                  o_rx_accept,
   output logic                  o_fifo_en,
   output logic      [LVL_W-1:0] o_rx_trigger,
   output logic      [LVL_W-1:0] o_tx_trigger,
   output logic                  o_flow_irq,
   output logic                  o_sample_tick,
   output logic                  o_bit_tick
);
   initial begin
      if (LVL_W != 7) $error("uft_flow: LVL_W must be 7 for a 64-entry fifo");
      if (DIV_W < 2 || DIV_W > 32) $error("uft_flow: DIV_W out of range");
   end

   typedef enum logic {UFT_FLOW_ON, UFT_FLOW_OFF} uft_flow_e;

   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // registers
   logic [7:0]       fifo_control;
   logic [7:0]       feature_control;
   logic [7:0]       enhanced_features;
   logic [7:0]       modem_control;
   logic [7:0]       interrupt_enable;
   logic             flow_event;
   logic [7:0]       rx_threshold_reg;
   logic [7:0]       tx_threshold_reg;
   logic [DIV_W-1:0] divisor;
   logic [1:0]       clock_config;
   logic             tx_halt;
   uft_flow_e        flow_state;
   logic             out_pin_q;
   logic             in_pin_q;

   // apb decode
   wire  acc       = psel && penable;
   wire  wr        = acc && pwrite;
   wire  rd        = acc && !pwrite;
   wire  hit_fc    = (paddr == uft_pkg::OFS_FIFO_CTL);
   wire  hit_ft    = (paddr == uft_pkg::OFS_FEAT_CTL);
   wire  hit_ef    = (paddr == uft_pkg::OFS_ENH_FEAT);
   wire  hit_mc    = (paddr == uft_pkg::OFS_MODEM_CTL);
   wire  hit_ie    = (paddr == uft_pkg::OFS_INT_EN);
   wire  hit_is    = (paddr == uft_pkg::OFS_INT_SRC);
   wire  hit_rt    = (paddr == uft_pkg::OFS_RX_THR);
   wire  hit_tt    = (paddr == uft_pkg::OFS_TX_THR);
   wire  hit_dv    = (paddr == uft_pkg::OFS_DIVISOR);
   wire  hit_cc    = (paddr == uft_pkg::OFS_CLK_CFG);
   wire  hit_st    = (paddr == uft_pkg::OFS_FLOW_STAT);
   wire  hit_any   = hit_fc || hit_ft || hit_ef || hit_mc || hit_ie || hit_is ||
                     hit_rt || hit_tt || hit_dv || hit_cc || hit_st;
   assign pready   = 1'b1;
   assign pslverr  = acc && !hit_any;

   // synchronised modem inputs
   logic [1:0] pins_sync;
   uft_sync #(.WIDTH(2)) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_async ({i_dsr_n, i_cts_n}),
      .o_sync  (pins_sync)
   );
   wire cts_n_s = pins_sync[0];
   wire dsr_n_s = pins_sync[1];

   // table lookups
   function automatic logic [6:0] rx_table(input logic [1:0] tbl,
                                           input logic [2:0] idx);
      logic [6:0] v;
      v = uft_pkg::FIFO_DEPTH;
      if (tbl == uft_pkg::TBL_A) v = uft_pkg::RX_A[idx];
      if (tbl == uft_pkg::TBL_B) v = uft_pkg::RX_B[idx];
      if (tbl == uft_pkg::TBL_C) v = uft_pkg::RX_C[idx];
      return v;
   endfunction

   function automatic logic [6:0] tx_table(input logic [1:0] tbl,
                                           input logic [1:0] idx);
      logic [6:0] v;
      v = uft_pkg::LVL_SINGLE;
      if (tbl == uft_pkg::TBL_B) v = uft_pkg::TX_B[idx];
      if (tbl == uft_pkg::TBL_C) v = uft_pkg::TX_C[idx];
      return v;
   endfunction

   wire [1:0] tbl     = feature_control[uft_pkg::FT_TBL_HI:uft_pkg::FT_TBL_LO];
   wire [1:0] rx_idx  = fifo_control[uft_pkg::FC_RX_HI:uft_pkg::FC_RX_LO];
   wire [1:0] tx_idx  = fifo_control[uft_pkg::FC_TX_HI:uft_pkg::FC_TX_LO];
   wire       tbl_d   = (tbl == uft_pkg::TBL_D);
   wire       fifo_on = fifo_control[uft_pkg::FC_FIFO_EN];

   wire [6:0] rx_prog = tbl_d ? rx_threshold_reg[6:0] : rx_table(tbl, {1'b0, rx_idx});
   wire [6:0] tx_prog = tbl_d ? tx_threshold_reg[6:0] : tx_table(tbl, tx_idx);
   assign o_fifo_en    = fifo_on;
   assign o_rx_trigger = fifo_on ? rx_prog : uft_pkg::LVL_SINGLE;
   assign o_tx_trigger = fifo_on ? tx_prog : uft_pkg::LVL_SINGLE;

   // halt and resume marks
   wire [6:0] hyst    = uft_pkg::HYST[feature_control[uft_pkg::FT_HYS_HI:
                                                      uft_pkg::FT_HYS_LO]];
   wire [7:0] d_hi    = {1'b0, rx_prog} + {1'b0, hyst};
   wire [7:0] d_lo    = {1'b0, rx_prog} - {1'b0, hyst};
   wire       d_under = (hyst >= rx_prog);
   wire [6:0] abc_hi  = rx_table(tbl, {1'b0, rx_idx} + 3'h1);
   wire [6:0] abc_lo  = (rx_idx == 2'h0) ? 7'h00 :
                        rx_table(tbl, {1'b0, rx_idx} - 3'h1);
   logic [6:0] o_rx_level_q;
   assign     o_rx_level_q = i_rx_level;
   wire [7:0] lvl8    = {1'b0, o_rx_level_q};

   // an underflowing low mark asserts only once the fifo is empty
   wire halt_hit   = tbl_d ? (lvl8 >= d_hi) : (o_rx_level_q >= abc_hi);
   wire resume_hit = tbl_d ? (d_under ? (o_rx_level_q == 7'h00) : (lvl8 < d_lo))
                           : (o_rx_level_q <= abc_lo);

   // rx intake is never gated by flow control, only by a full fifo
   assign o_rx_accept = (o_rx_level_q < uft_pkg::FIFO_DEPTH);

   // output pin selection
   wire dtr_mode  = modem_control[uft_pkg::MC_DTR_MODE];
   wire auto_out  = enhanced_features[uft_pkg::EF_AUTO_RTS];
   wire auto_in   = enhanced_features[uft_pkg::EF_AUTO_CTS];
   wire sw_assert = dtr_mode ? modem_control[uft_pkg::MC_DTR]
                             : modem_control[uft_pkg::MC_RTS];
   wire flow_pin_n = !(sw_assert && (!auto_out || flow_state == UFT_FLOW_ON));
   wire rts_pin_n  = dtr_mode ? !modem_control[uft_pkg::MC_RTS] : flow_pin_n;
   wire dtr_pin_n  = dtr_mode ? flow_pin_n : !modem_control[uft_pkg::MC_DTR];
   assign o_rts_n  = rts_pin_n;
   assign o_dtr_n  = dtr_pin_n;

   // flow state machine: halt/resume marks only act while running
   uft_flow_e  next_flow;
   always_comb begin
      next_flow     = flow_state;
      unique case (flow_state)
         UFT_FLOW_ON: begin
            if (auto_out && sw_assert && halt_hit) next_flow = UFT_FLOW_OFF;
         end
         UFT_FLOW_OFF: begin
            if (!auto_out || !sw_assert || resume_hit) next_flow = UFT_FLOW_ON;
         end
      endcase
   end

   // transmit gating on the selected input
   wire in_pin_n  = dtr_mode ? dsr_n_s : cts_n_s;
   wire gate_stop = auto_in && in_pin_n;
   // halting only between characters, so the stop bit always completes
   wire next_halt = gate_stop ? (tx_halt || i_tx_idle) : 1'b0;
   assign o_tx_allow = !tx_halt && !(gate_stop && i_tx_idle);

   // pin transition events
   wire out_edge  = (flow_pin_n != out_pin_q) && interrupt_enable[uft_pkg::IE_OUT_IRQ];
   wire in_edge   = (in_pin_n != in_pin_q) && interrupt_enable[uft_pkg::IE_IN_IRQ];
   wire is_read   = rd && hit_is;
   // set wins over the clear-on-read; a read clears only an event it reported
   wire seen_clr  = is_read && prdata[uft_pkg::IS_FLOW];
   wire next_event = (out_edge || in_edge) || (flow_event && !seen_clr);
   assign o_flow_irq = flow_event;

   wire ie_wr_ok  = enhanced_features[uft_pkg::EF_ENHANCE];

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         flow_state <= UFT_FLOW_ON;
         tx_halt    <= 1'b0;
         flow_event <= 1'b0;
         out_pin_q  <= 1'b1;
         in_pin_q   <= 1'b1;
      end else begin
         flow_state <= next_flow;
         tx_halt    <= next_halt;
         flow_event <= next_event;
         out_pin_q  <= flow_pin_n;
         in_pin_q   <= in_pin_n;
      end
   end

   // register writes
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_control      <= uft_pkg::RST_BYTE;
         feature_control   <= uft_pkg::RST_BYTE;
         enhanced_features <= uft_pkg::RST_BYTE;
         modem_control     <= uft_pkg::RST_BYTE;
         interrupt_enable  <= uft_pkg::RST_BYTE;
         rx_threshold_reg  <= uft_pkg::RST_THR;
         tx_threshold_reg  <= uft_pkg::RST_THR;
         divisor           <= DIV_W'(uft_pkg::RST_DIVISOR);
         clock_config      <= 2'h0;
      end else if (wr) begin
         if (hit_fc) fifo_control      <= pwdata[7:0];
         if (hit_ft) feature_control   <= pwdata[7:0];
         if (hit_ef) enhanced_features <= pwdata[7:0];
         if (hit_mc) modem_control     <= pwdata[7:0];
         if (hit_ie) begin
            // upper enables stay locked until enhanced mode is on
            interrupt_enable[5:0] <= pwdata[5:0];
            if (ie_wr_ok) interrupt_enable[7:6] <= pwdata[7:6];
         end
         if (hit_rt) rx_threshold_reg  <= pwdata[7:0];
         if (hit_tt) tx_threshold_reg  <= pwdata[7:0];
         if (hit_dv) divisor           <= pwdata[DIV_W-1:0];
         if (hit_cc) clock_config      <= pwdata[1:0];
      end
   end

   // read mux
   logic [7:0] int_src;
   always_comb begin
      int_src                   = 8'h00;
      int_src[uft_pkg::IS_FLOW] = flow_event;
      int_src[uft_pkg::IS_NONE] = !flow_event;
   end

   wire [31:0] stat_word = {16'h0000, 1'b0, o_rx_level_q, 3'h0, tx_halt,
                            dsr_n_s, cts_n_s, dtr_pin_n, rts_pin_n};
   wire [31:0] rd_mux =
      hit_fc ? {24'h000000, fifo_control}      :
      hit_ft ? {24'h000000, feature_control}   :
      hit_ef ? {24'h000000, enhanced_features} :
      hit_mc ? {24'h000000, modem_control}     :
      hit_ie ? {24'h000000, interrupt_enable}  :
      hit_is ? {24'h000000, int_src}           :
      hit_rt ? {24'h000000, rx_threshold_reg}  :
      hit_tt ? {24'h000000, tx_threshold_reg}  :
      hit_dv ? 32'(divisor)                    :
      hit_cc ? {30'h00000000, clock_config}    :
      hit_st ? stat_word                       : 32'h00000000;

   // read data registered during setup so it is stable in the access phase
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   uft_baud #(.DIV_W(DIV_W)) u_baud (
      .i_clk         (i_clk),
      .i_rst_n       (rst_n),
      .i_presc4      (clock_config[uft_pkg::CC_PRESC4]),
      .i_ovs8        (clock_config[uft_pkg::CC_OVS8]),
      .i_divisor     (divisor),
      .o_sample_tick (o_sample_tick),
      .o_bit_tick    (o_bit_tick)
   );
endmodule // uft_flow

// ---- core/uft_pkg.sv ----
// uft_pkg: register map, field positions, reset values and trigger tables
// for one channel's trigger-level and hardware flow control logic.
// assumes 32-bit apb with word-aligned registers.
package uft_pkg;
   localparam int          AW            = 8;
   localparam logic [7:0]  OFS_FIFO_CTL  = 8'h00;
   localparam logic [7:0]  OFS_FEAT_CTL  = 8'h04;
   localparam logic [7:0]  OFS_ENH_FEAT  = 8'h08;
   localparam logic [7:0]  OFS_MODEM_CTL = 8'h0c;
   localparam logic [7:0]  OFS_INT_EN    = 8'h10;
   localparam logic [7:0]  OFS_INT_SRC   = 8'h14;
   localparam logic [7:0]  OFS_RX_THR    = 8'h18;
   localparam logic [7:0]  OFS_TX_THR    = 8'h1c;
   localparam logic [7:0]  OFS_DIVISOR   = 8'h20;
   localparam logic [7:0]  OFS_CLK_CFG   = 8'h24;
   localparam logic [7:0]  OFS_FLOW_STAT = 8'h28;

   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [7:0]  RST_INT_SRC   = 8'h01;
   localparam logic [15:0] RST_DIVISOR   = 16'h0001;
   localparam logic [7:0]  RST_THR       = 8'h01;

   // fifo_control
   localparam int FC_FIFO_EN  = 0;
   localparam int FC_RX_HI    = 7;
   localparam int FC_RX_LO    = 6;
   localparam int FC_TX_HI    = 5;
   localparam int FC_TX_LO    = 4;
   // feature_control
   localparam int FT_TBL_HI   = 7;
   localparam int FT_TBL_LO   = 6;
   localparam int FT_HYS_HI   = 3;
   localparam int FT_HYS_LO   = 0;
   // enhanced_features
   localparam int EF_AUTO_CTS = 7;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_ENHANCE  = 4;
   // modem_control
   localparam int MC_DTR_MODE = 2;
   localparam int MC_RTS      = 1;
   localparam int MC_DTR      = 0;
   // interrupt_enable / interrupt_source
   localparam int IE_IN_IRQ   = 7;
   localparam int IE_OUT_IRQ  = 6;
   localparam int IS_FLOW     = 5;
   localparam int IS_NONE     = 0;
   // clock_config
   localparam int CC_PRESC4   = 0;
   localparam int CC_OVS8     = 1;

   localparam logic [1:0] TBL_A = 2'b00;
   localparam logic [1:0] TBL_B = 2'b01;
   localparam logic [1:0] TBL_C = 2'b10;
   localparam logic [1:0] TBL_D = 2'b11;

   localparam logic [6:0] LVL_SINGLE = 7'h01;
   localparam logic [6:0] FIFO_DEPTH = 7'h40;
   // receive tables a, b, c; entry 4 stands for a full fifo
   localparam logic [6:0] RX_A [5] = '{7'h01, 7'h04, 7'h08, 7'h0e, 7'h40};
   localparam logic [6:0] RX_B [5] = '{7'h08, 7'h10, 7'h18, 7'h1c, 7'h40};
   localparam logic [6:0] RX_C [5] = '{7'h08, 7'h10, 7'h38, 7'h3c, 7'h40};
   localparam logic [6:0] TX_B [4] = '{7'h10, 7'h08, 7'h18, 7'h1e};
   localparam logic [6:0] TX_C [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
   // hysteresis per feature_control code
   localparam logic [6:0] HYST [16] = '{7'h00, 7'h04, 7'h06, 7'h08,
                                        7'h08, 7'h10, 7'h18, 7'h20,
                                        7'h28, 7'h2c, 7'h30, 7'h34,
                                        7'h0c, 7'h14, 7'h1c, 7'h24};

   localparam logic [1:0] PRESC_DIV4 = 2'h3;
   localparam logic [4:0] OVS_8      = 5'h08;
   localparam logic [4:0] OVS_16     = 5'h10;
endpackage

// ---- core/uft_sync.sv ----
// uft_sync: two flip-flop synchroniser for asynchronous pin inputs.
// assumes inputs are idle high (active-low modem lines).
`timescale 1ns/100ps
module uft_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   initial begin
      if (WIDTH < 1) $error("uft_sync: WIDTH must be at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta;
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta        <= 1'b1;
               o_sync[g]   <= 1'b1;
            end else begin
               meta        <= i_async[g];
               o_sync[g]   <= meta;
            end
         end
      end
   endgenerate
endmodule // uft_sync

// ---- tb/uft_flow_test.sv ----
// uft_flow_test: self-checking bench for trigger levels and flow control.
// assumes an apb master here and the remote model on the far side.
`timescale 1ns/100ps
module uft_flow_test;
   logic        i_clk, i_resetn, psel, penable, pwrite, i_tx_idle, i_cts_n, i_dsr_n;
   logic        pready, pslverr, o_rts_n, o_dtr_n, o_tx_allow, o_rx_accept, o_fifo_en;
   logic        o_flow_irq, o_sample_tick, o_bit_tick, obey, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0]  lvl, tgt, o_rx_trigger, o_tx_trigger;
   int          errors, comparisons, n;
   localparam logic [29:0] ROWS [14] = '{
      {8'h00,8'h01,7'h01,7'h01}, {8'h00,8'h51,7'h04,7'h01}, {8'h00,8'ha1,7'h08,7'h01},
      {8'h00,8'hf1,7'h0e,7'h01}, {8'h40,8'h01,7'h08,7'h10}, {8'h40,8'h51,7'h10,7'h08},
      {8'h40,8'ha1,7'h18,7'h18}, {8'h40,8'hf1,7'h1c,7'h1e}, {8'h80,8'h01,7'h08,7'h08},
      {8'h80,8'h51,7'h10,7'h10}, {8'h80,8'ha1,7'h38,7'h20}, {8'h80,8'hf1,7'h3c,7'h38},
      {8'hc0,8'h01,7'h20,7'h05}, {8'h40,8'hf0,7'h01,7'h01}};
   localparam logic [10:0] HYS [3] = '{{4'h1,7'h04}, {4'hc,7'h0c}, {4'h5,7'h10}};
   localparam logic [10:0] BAUD [4] = '{{2'h0,2'h1,7'h10}, {2'h2,2'h1,7'h08},
      {2'h1,2'h1,7'h40}, {2'h2,2'h3,7'h18}};
   uft_flow dut (.i_clk, .i_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .i_rx_level(lvl), .i_tx_idle, .i_cts_n, .i_dsr_n, .o_rts_n,
      .o_dtr_n, .o_tx_allow, .o_rx_accept, .o_fifo_en, .o_rx_trigger, .o_tx_trigger,
      .o_flow_irq, .o_sample_tick, .o_bit_tick);
   uft_remote u_far (.i_clk, .i_rts_n(o_rts_n), .i_obey(obey), .i_target(tgt),
      .o_level(lvl));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   // zero wait states are not assumed: the access phase holds until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic go(input logic [6:0] v);
      tgt = v;
      n = 0;
      while (lvl !== v && n < 80) begin
         cyc(1);
         n++;
      end
      cyc(2);
   endtask
   task automatic tick(output int c);
      c = 0;
      do begin
         @(posedge i_clk);
         #1;
         c++;
      end while (o_bit_tick !== 1'b1 && c < 300);
   endtask
   task automatic summarize();
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      summarize();
   end
   initial begin
      {errors, comparisons, obey, tgt, i_resetn, psel, penable, pwrite} = '0;
      {paddr, pwdata, i_cts_n, i_dsr_n, i_tx_idle} = {40'h0, 3'b001};
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      cyc(3);
      chk({o_fifo_en, o_rx_trigger, o_tx_trigger, o_rts_n, o_dtr_n}, 17'h00207);
      apb(0, uft_pkg::OFS_INT_SRC, 0);
      chk(rdat, 32'h01);
      apb(0, 8'h3c, 0);
      chk({rerr, pready, rdat[29:0]}, 32'hc0000000);
      apb(1, uft_pkg::OFS_RX_THR, 32'h20);
      apb(1, uft_pkg::OFS_TX_THR, 32'h05);
      foreach (ROWS[i]) begin
         apb(1, uft_pkg::OFS_FEAT_CTL, {24'h0, ROWS[i][29:22]});
         apb(1, uft_pkg::OFS_FIFO_CTL, {24'h0, ROWS[i][21:14]});
         cyc(1);
         chk({o_fifo_en, o_rx_trigger, o_tx_trigger}, ROWS[i][14:0]);
      end
      apb(1, uft_pkg::OFS_INT_EN, 32'h40);
      apb(0, uft_pkg::OFS_INT_EN, 0);
      chk(rdat, 32'h00);
      apb(1, uft_pkg::OFS_ENH_FEAT, 32'h10);
      apb(1, uft_pkg::OFS_INT_EN, 32'h40);
      apb(0, uft_pkg::OFS_INT_EN, 0);
      chk(rdat, 32'h40);
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h02);
      chk({o_rts_n, o_dtr_n}, 2'b01);
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h01);
      chk({o_rts_n, o_dtr_n}, 2'b10);
      apb(1, uft_pkg::OFS_FEAT_CTL, 32'h00);
      apb(1, uft_pkg::OFS_FIFO_CTL, 32'h51);
      apb(1, uft_pkg::OFS_ENH_FEAT, 32'h50);
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h00);
      go(2);
      chk(o_rts_n, 1'b1);
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h02);
      go(7);
      chk(o_rts_n, 1'b0);
      apb(0, uft_pkg::OFS_INT_SRC, 0);
      obey = 1'b1;
      go(20);
      chk({lvl, o_rts_n, o_flow_irq}, 9'h27);
      apb(0, uft_pkg::OFS_INT_SRC, 0);
      chk(rdat, 32'h20);
      apb(0, uft_pkg::OFS_INT_SRC, 0);
      chk({rdat[30:0], o_flow_irq}, 32'h2);
      obey = 1'b0;
      go(2);
      chk(o_rts_n, 1'b1);
      go(1);
      chk(o_rts_n, 1'b0);
      go(64);
      chk({lvl, o_rx_accept, o_rts_n}, 9'h101);
      go(0);
      apb(1, uft_pkg::OFS_FIFO_CTL, 32'h01);
      foreach (HYS[i]) begin
         apb(1, uft_pkg::OFS_FEAT_CTL, {24'h0, 4'hc, HYS[i][10:7]});
         go(7'h1f + HYS[i][6:0]);
         chk(o_rts_n, 1'b0);
         go(7'h20 + HYS[i][6:0]);
         chk(o_rts_n, 1'b1);
         go(7'h20 - HYS[i][6:0]);
         chk(o_rts_n, 1'b1);
         go(7'h1f - HYS[i][6:0]);
         chk(o_rts_n, 1'b0);
      end
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h05);
      go(47);
      chk({o_rts_n, o_dtr_n}, 2'b10);
      go(48);
      chk({o_rts_n, o_dtr_n}, 2'b11);
      go(0);
      apb(1, uft_pkg::OFS_ENH_FEAT, 32'h90);
      apb(1, uft_pkg::OFS_INT_EN, 32'h80);
      apb(0, uft_pkg::OFS_INT_SRC, 0);
      i_tx_idle <= 1'b0;
      i_dsr_n <= 1'b1;
      cyc(6);
      chk({o_tx_allow, o_flow_irq}, 2'b11);
      i_tx_idle <= 1'b1;
      cyc(6);
      chk(o_tx_allow, 1'b0);
      i_cts_n <= 1'b1;
      i_dsr_n <= 1'b0;
      cyc(6);
      chk(o_tx_allow, 1'b1);
      apb(1, uft_pkg::OFS_MODEM_CTL, 32'h02);
      cyc(4);
      chk(o_tx_allow, 1'b0);
      apb(1, uft_pkg::OFS_ENH_FEAT, 32'h40);
      cyc(4);
      chk(o_tx_allow, 1'b1);
      i_cts_n <= 1'b0;
      foreach (BAUD[i]) begin
         apb(1, uft_pkg::OFS_CLK_CFG, {30'h0, BAUD[i][10:9]});
         apb(1, uft_pkg::OFS_DIVISOR, {30'h0, BAUD[i][8:7]});
         tick(n);
         tick(n);
         tick(n);
         chk(n, BAUD[i][6:0]);
         chk(o_sample_tick, 1'b1);
      end
      @(posedge i_clk);
      i_resetn <= 1'b0;
      cyc(2);
      chk({o_rts_n, o_fifo_en, o_rx_trigger}, 9'h101);
      i_resetn <= 1'b1;
      cyc(3);
      apb(0, uft_pkg::OFS_FIFO_CTL, 0);
      chk(rdat, 32'h00);
      summarize();
   end
endmodule // uft_flow_test

// ---- tb/uft_monitor.sv ----
// uft_monitor: port-level checks of the flow control block.
// assumes one i_clk domain and the active-low i_resetn.
`timescale 1ns/100ps
module uft_monitor #(
   parameter int LVL_W = 7
) (
   input wire logic             i_clk,
   input wire logic             i_resetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [LVL_W-1:0] i_rx_level,
   input wire logic             i_tx_idle,
   input wire logic             i_cts_n,
   input wire logic             i_dsr_n,
   input wire logic             o_rts_n,
   input wire logic             o_dtr_n,
   input wire logic             o_tx_allow,
   input wire logic             o_rx_accept,
   input wire logic             o_fifo_en,
   input wire logic [LVL_W-1:0] o_rx_trigger,
   input wire logic [LVL_W-1:0] o_tx_trigger,
   input wire logic             o_flow_irq,
   input wire logic             o_bit_tick
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire        wr_acc = psel && penable && pwrite;
   wire  [3:0] pins   = {o_rts_n, o_dtr_n, i_cts_n, i_dsr_n};
   logic [3:0] pins_q;
   logic [3:0] since;
   wire        chg    = pins != pins_q;
   // inputs pass two sync flops, so an event may trail its pin a few cycles
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pins_q <= 4'hf;
         since  <= 4'h0;
      end else begin
         pins_q <= pins;
         since  <= chg ? 4'h0 : (since == 4'hf ? since : since + 4'h1);
      end
   end
   a_trig_single: assert property (!o_fifo_en |->
      o_rx_trigger == 1 && o_tx_trigger == 1) else $error("trigger not one");
   a_rx_accept: assert property (o_rx_accept == (i_rx_level < 64))
      else $error("accept wrong");
   a_rts_rise: assert property ($rose(o_rts_n) |-> $past(i_rx_level) != 0 ||
      $past(wr_acc) || $past(wr_acc, 2)) else $error("rts off without cause");
   a_rts_fall: assert property ($fell(o_rts_n) |-> $past(i_rx_level) < 64 ||
      $past(wr_acc) || $past(wr_acc, 2)) else $error("rts on while full");
   a_irq_cause: assert property ($rose(o_flow_irq) |-> since < 8 || chg)
      else $error("flow irq without pin change");
   a_halt_idle: assert property ($fell(o_tx_allow) |-> i_tx_idle)
      else $error("halt inside a character");
   a_halt_cause: assert property ($fell(o_tx_allow) |-> i_cts_n || i_dsr_n)
      else $error("halt with inputs low");
   a_bit_space: assert property (o_bit_tick |=> !o_bit_tick [*7])
      else $error("bit ticks too close");
   c_rts_off: cover property ($rose(o_rts_n));
   c_irq: cover property ($rose(o_flow_irq));
   c_halt: cover property ($fell(o_tx_allow));
endmodule // uft_monitor
bind uft_flow uft_monitor #(.LVL_W(LVL_W)) u_mon (.i_clk(i_clk), .i_resetn(i_resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .i_rx_level(i_rx_level),
   .i_tx_idle(i_tx_idle), .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .o_rts_n(o_rts_n),
   .o_dtr_n(o_dtr_n), .o_tx_allow(o_tx_allow), .o_rx_accept(o_rx_accept),
   .o_fifo_en(o_fifo_en), .o_rx_trigger(o_rx_trigger), .o_tx_trigger(o_tx_trigger),
   .o_flow_irq(o_flow_irq), .o_bit_tick(o_bit_tick));

// ---- tb/uft_remote.sv ----
// uft_remote: far-end transmitter filling the local receive fifo.
// assumes the local reader drains toward the level the bench asks for.
`timescale 1ns/100ps
module uft_remote (
   input  wire logic       i_clk,
   input  wire logic       i_rts_n,
   input  wire logic       i_obey,
   input  wire logic [6:0] i_target,
   output logic      [6:0] o_level
);
   initial o_level = 7'h00;
   // a remote that ignores the request keeps sending up to i_target, at most until the fifo is full
   always @(posedge i_clk) begin
      if (o_level < i_target && o_level < 7'h40 && !(i_obey && i_rts_n))
         o_level <= o_level + 7'h01;
      else if (o_level > i_target)
         o_level <= o_level - 7'h01;
   end
endmodule // uft_remote
